// [rtl/abw_pkg.sv]
// Package for the access bank window remap block
package abw_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int OPND_W = 8;
	localparam int BANK_W = 4;
	typedef logic [ADDR_W-1:0] abw_addr_t;
	// ------------------------------------------------------------
	// Map constants
	// ------------------------------------------------------------
	localparam logic [OPND_W-1:0] WIN_LAST = 8'h5F;
	localparam logic [ADDR_W-1:0] WIN_SPAN_M1 = 12'h05F;
	localparam logic [ADDR_W-1:0] ACC_HIGH_BASE = 12'hF00;
	localparam logic [ADDR_W-1:0] RST_ADDR = 12'h000;
	typedef enum logic [1:0] {ABW_DIRECT, ABW_WINDOW, ABW_BANKED, ABW_INDIRECT} abw_route_e;
endpackage

// [rtl/abw_adder.sv]
// Window address adder
`timescale 1ns/100ps
module abw_adder (
	input wire logic [abw_pkg::ADDR_W-1:0] base_i,
	input wire logic [6:0] offset_i,
	output logic [abw_pkg::ADDR_W-1:0] sum_o
);
	import abw_pkg::*;
	// Wraps at the top of data memory, as the pointer itself does
	always_comb begin
		sum_o = base_i + {5'h00, offset_i};
	end
endmodule

// [rtl/abw_remap.sv]
// Access bank address remap for indexed literal offset mode
// Operation
// - In indexed mode, access operand 00h-5Fh is redirected into a movable window.
// - Window spans window base pointer up to base plus 95.
// - Access operands above 5Fh keep direct addressing and normal access map.
// - Only indexed literal offset operations see the window redirection.
// - Access select bit 1 uses bank select register, never redirected.
// - Explicit indirect operands, including the base pointer, use plain indirect.
// - Remapping applies only with the extended instruction set enabled.
`timescale 1ns/100ps
module abw_remap (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic valid_i,
	input wire logic ext_set_en_i,
	input wire logic indexed_op_i,
	input wire logic access_sel_i,
	input wire logic indirect_op_i,
	input wire logic [abw_pkg::OPND_W-1:0] operand_i,
	input wire logic [abw_pkg::BANK_W-1:0] bank_select_register_i,
	input wire logic [abw_pkg::ADDR_W-1:0] window_base_pointer_i,
	input wire logic [abw_pkg::ADDR_W-1:0] indirect_addr_i,
	output logic valid_o,
	output logic [abw_pkg::ADDR_W-1:0] addr_o,
	output logic [1:0] route_o
);
	import abw_pkg::*;
	// ------------------------------------------------------------
	// Route decode
	// ------------------------------------------------------------
	logic win_hit;
	abw_route_e route;
	abw_addr_t win_addr;
	abw_addr_t addr_d, addr_q;
	logic valid_d, valid_q;
	logic [1:0] route_d, route_q;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Low access range test, shared by the window decode and the normal map
	function automatic logic low_access(input logic [OPND_W-1:0] opnd);
		low_access = (opnd <= WIN_LAST);
	endfunction

	// Remapping needs both the extended set and an indexed literal offset op
	function automatic logic remap_mode(input logic ext_en, input logic indexed);
		remap_mode = ext_en && indexed;
	endfunction

	abw_adder u_adder (
		.base_i(window_base_pointer_i),
		.offset_i(operand_i[6:0]),
		.sum_o(win_addr)
	);

	// Indirect wins first: an explicit pointer operand never goes through the window
	always_comb begin
		win_hit = remap_mode(ext_set_en_i, indexed_op_i) && low_access(operand_i);
		if (indirect_op_i) begin
			route = ABW_INDIRECT;
		end else if (access_sel_i) begin
			route = ABW_BANKED;
		end else if (win_hit) begin
			route = ABW_WINDOW;
		end else begin
			route = ABW_DIRECT;
		end
	end

	always_comb begin
		unique case (route)
			ABW_INDIRECT: addr_d = indirect_addr_i;
			ABW_BANKED: addr_d = {bank_select_register_i, operand_i};
			ABW_WINDOW: addr_d = win_addr;
			ABW_DIRECT: begin
				// Normal access map: 00h-5Fh in bank 0, 60h-FFh in the top bank
				if (!low_access(operand_i)) begin
					addr_d = ACC_HIGH_BASE | {4'h0, operand_i};
				end else begin
					addr_d = {4'h0, operand_i};
				end
			end
		endcase
		valid_d = valid_i;
		route_d = route;
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_q <= RST_ADDR;
			valid_q <= 1'b0;
			route_q <= ABW_DIRECT;
		end else begin
			addr_q <= addr_d;
			valid_q <= valid_d;
			route_q <= route_d;
		end
	end

	assign addr_o = addr_q;
	assign valid_o = valid_q;
	assign route_o = route_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// Operand classes at the request edge
	// ------------------------------------------------------------
	// Same priority as the decode, so no two routing classes overlap
	sequence s_indirect;
		indirect_op_i;
	endsequence
	sequence s_banked;
		!indirect_op_i && access_sel_i;
	endsequence
	sequence s_banked_ext;
		!indirect_op_i && access_sel_i && ext_set_en_i && indexed_op_i;
	endsequence
	sequence s_pointer_in_mode;
		indirect_op_i && ext_set_en_i && indexed_op_i;
	endsequence
	sequence s_window;
		!indirect_op_i && !access_sel_i && ext_set_en_i && indexed_op_i
			&& operand_i <= WIN_LAST;
	endsequence
	sequence s_window_first;
		s_window ##0 (operand_i == 8'h00);
	endsequence
	sequence s_window_last;
		s_window ##0 (operand_i == WIN_LAST);
	endsequence
	sequence s_access_high;
		!indirect_op_i && !access_sel_i && operand_i > WIN_LAST;
	endsequence
	sequence s_high_in_mode;
		!indirect_op_i && !access_sel_i && ext_set_en_i && indexed_op_i
			&& operand_i > WIN_LAST;
	endsequence
	sequence s_access_plain;
		!indirect_op_i && !access_sel_i && !(ext_set_en_i && indexed_op_i)
			&& operand_i <= WIN_LAST;
	endsequence

	// ------------------------------------------------------------
	// Window checks
	// ------------------------------------------------------------
	a_window_span: assert property (s_window
		|=> (addr_o - $past(window_base_pointer_i)) <= WIN_SPAN_M1)
		else $error("window address outside span");
	a_window_sum: assert property (s_window
		|=> addr_o == $past(window_base_pointer_i) + {5'h00, $past(operand_i[6:0])})
		else $error("window address not base plus offset");
	a_window_first: assert property (s_window_first
		|=> addr_o == $past(window_base_pointer_i))
		else $error("window does not start at base");
	a_window_last: assert property (s_window_last
		|=> addr_o == $past(window_base_pointer_i) + WIN_SPAN_M1)
		else $error("window does not end at base plus span");
	a_window_route: assert property (s_window
		|=> route_o == ABW_WINDOW)
		else $error("low access operand not redirected");

	// ------------------------------------------------------------
	// Normal map checks
	// ------------------------------------------------------------
	a_high_direct: assert property (s_access_high
		|=> addr_o == (ACC_HIGH_BASE | {4'h0, $past(operand_i)}))
		else $error("high access operand remapped");
	a_high_in_mode: assert property (s_high_in_mode
		|=> addr_o == (ACC_HIGH_BASE | {4'h0, $past(operand_i)}))
		else $error("high access operand remapped in indexed mode");
	a_high_route: assert property (s_access_high
		|=> route_o == ABW_DIRECT)
		else $error("high access operand not routed direct");
	a_no_ext_direct: assert property (!ext_set_en_i && !indirect_op_i && !access_sel_i
		&& operand_i <= WIN_LAST |=> addr_o == {4'h0, $past(operand_i)})
		else $error("remap without extended set");
	a_no_ext_route: assert property (!ext_set_en_i && !indirect_op_i && !access_sel_i
		|=> route_o == ABW_DIRECT)
		else $error("window route without extended set");
	a_plain_low: assert property (s_access_plain
		|=> addr_o == {4'h0, $past(operand_i)})
		else $error("low access operand moved outside indexed mode");
	a_non_indexed: assert property (!indexed_op_i && !indirect_op_i && !access_sel_i
		|=> route_o == ABW_DIRECT)
		else $error("non-indexed op redirected");

	// ------------------------------------------------------------
	// Banked and indirect checks
	// ------------------------------------------------------------
	a_banked_path: assert property (s_banked
		|=> addr_o == {$past(bank_select_register_i), $past(operand_i)})
		else $error("banked access altered");
	a_banked_route: assert property (s_banked
		|=> route_o == ABW_BANKED)
		else $error("banked access not routed banked");
	a_banked_ext: assert property (s_banked_ext
		|=> addr_o == {$past(bank_select_register_i), $past(operand_i)})
		else $error("bank select altered by extended set");
	a_indirect_path: assert property (s_indirect
		|=> addr_o == $past(indirect_addr_i))
		else $error("indirect access remapped");
	a_indirect_route: assert property (s_indirect
		|=> route_o == ABW_INDIRECT)
		else $error("indirect access not routed indirect");
	a_pointer_plain: assert property (s_pointer_in_mode
		|=> addr_o == $past(indirect_addr_i))
		else $error("pointer operand remapped in indexed mode");

	// ------------------------------------------------------------
	// Output register checks
	// ------------------------------------------------------------
	a_valid_follow: assert property (valid_i |=> valid_o)
		else $error("valid not forwarded");
	a_valid_drop: assert property (!valid_i |=> !valid_o)
		else $error("valid raised without request");
	a_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0) rst_i
		|=> !valid_o && addr_o == RST_ADDR && route_o == ABW_DIRECT)
		else $error("outputs not cleared by reset");
endmodule

// [testbench/abw_cpu_model.sv]
// Operand path model of the CPU side feeding the remap block
`timescale 1ns/100ps
module abw_cpu_model (
	input wire logic [40:0] op_i,
	output logic valid_o,
	output logic [3:0] flags_o,
	output logic [7:0] operand_o,
	output logic [3:0] bank_o,
	output logic [11:0] base_o,
	output logic [11:0] ind_addr_o
);
	// The decode stage presents one operation per cycle, already aligned to the edge
	assign {valid_o, flags_o, operand_o, bank_o, base_o, ind_addr_o} = op_i;
endmodule

// [testbench/tb_access_bank_window_remap.sv]
// Testbench for the access bank window remap block
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_access_bank_window_remap;
	import abw_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [40:0] op = '0;
	int miscompares = 0;
	int n_tests = 0;
	logic v_w, valid_o;
	logic [3:0] f_w, b_w;
	logic [7:0] o_w;
	logic [11:0] base_w, ia_w, addr_o;
	logic [1:0] route_o;
	abw_cpu_model i_abw_cpu_model (.op_i(op), .valid_o(v_w), .flags_o(f_w), .operand_o(o_w),
		.bank_o(b_w), .base_o(base_w), .ind_addr_o(ia_w));
	abw_remap i_abw_remap (.clk_i(clk_i), .rst_i(rst_i), .valid_i(v_w), .ext_set_en_i(f_w[3]),
		.indexed_op_i(f_w[2]), .access_sel_i(f_w[1]), .indirect_op_i(f_w[0]),
		.operand_i(o_w), .bank_select_register_i(b_w), .window_base_pointer_i(base_w),
		.indirect_addr_i(ia_w), .valid_o(valid_o), .addr_o(addr_o), .route_o(route_o));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Flags are {extended set, indexed, access select, indirect}
	task automatic go(input logic [3:0] f, input logic [7:0] o, input logic [11:0] b,
		input logic [11:0] ea, input logic [1:0] er);
		@(posedge clk_i);
		op <= {1'b1, f, o, 4'hA, b, 12'h3C5};
		@(posedge clk_i);
		#1;
		`CHK(valid_o, 1'b1)
		`CHK(addr_o, ea)
		`CHK(route_o, er)
	endtask
	task automatic t_window;
		go(4'hC, 8'h00, 12'h123, 12'h123, ABW_WINDOW);
		go(4'hC, 8'h5F, 12'h123, 12'h182, ABW_WINDOW);
		go(4'hC, 8'h5F, 12'hFF0, 12'h04F, ABW_WINDOW);
		go(4'hC, 8'h60, 12'h123, 12'hF60, ABW_DIRECT);
		$display("t_window done");
	endtask
	task automatic t_modes;
		go(4'h8, 8'h05, 12'h123, 12'h005, ABW_DIRECT);
		go(4'h4, 8'h05, 12'h123, 12'h005, ABW_DIRECT);
		$display("t_modes done");
	endtask
	task automatic t_banked;
		go(4'hE, 8'h05, 12'h123, 12'hA05, ABW_BANKED);
		$display("t_banked done");
	endtask
	task automatic t_indirect;
		go(4'hD, 8'h05, 12'h123, 12'h3C5, ABW_INDIRECT);
		go(4'hF, 8'h05, 12'h123, 12'h3C5, ABW_INDIRECT);
		$display("t_indirect done");
	endtask
	// Valid low still maps the address, but must not show as a request
	task automatic t_idle;
		@(posedge clk_i);
		op <= {1'b0, 4'hC, 8'h10, 4'hA, 12'h123, 12'h3C5};
		@(posedge clk_i);
		#1;
		`CHK(valid_o, 1'b0)
		`CHK(addr_o, 12'h133)
		`CHK(route_o, ABW_WINDOW)
		$display("t_idle done");
	endtask
	// Reset in mid-run, then a request on the first edge after release
	task automatic t_reset;
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK(valid_o, 1'b0)
		`CHK(addr_o, RST_ADDR)
		`CHK(route_o, ABW_DIRECT)
		go(4'hC, 8'h01, 12'h200, 12'h201, ABW_WINDOW);
		$display("t_reset done");
	endtask
	task automatic test_done;
		$display("n_tests=%0d miscompares=%0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (500) @(posedge clk_i);
		miscompares++;
		test_done();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK(valid_o, 1'b0)
		`CHK(addr_o, RST_ADDR)
		`CHK(route_o, ABW_DIRECT)
		t_window();
		t_modes();
		t_banked();
		t_indirect();
		t_idle();
		t_reset();
		test_done();
	end
endmodule
